/* File: src/icg_pkg.sv */
package icg_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PRI_HIGH = 8'h04;
  localparam logic [7:0] OFF_PRI_LOW = 8'h08;
  localparam logic [7:0] OFF_SEC_HIGH = 8'h0C;
  localparam logic [7:0] OFF_SEC_LOW = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // Control register fields
  localparam int BIT_ENABLE = 0;
  localparam int BIT_BASEBAND = 1;
  localparam int BIT_FSK = 2;
  localparam int BIT_HALVE = 6;

  // Data register fields
  localparam int CNT_W = 6;
  localparam int BIT_LATCH = 7;

  // Status register fields
  localparam int BIT_ST_CARRIER = 6;
  localparam int BIT_ST_PHASE = 7;
  localparam int BIT_ST_SET = 8;

  // Reset values
  localparam logic [CNT_W-1:0] RST_COUNT = 6'h00;
  localparam logic RST_LATCH = 1'b0;

  // Timing: one count step is one oscillator period
  localparam int CLK_PERIOD_PS = 4000;
  localparam int STEP_TIME_PS = 4000;
  localparam int STEP_CYCLES = (STEP_TIME_PS / CLK_PERIOD_PS < 1) ? 1 :
                               STEP_TIME_PS / CLK_PERIOD_PS;
  // Modulator time baseband_select: one tick per eight oscillator periods, sixteen with halve select set
  localparam int MOD_TICK_DIV = 8;
  localparam logic [2:0] MOD_TICK_LAST = 3'(MOD_TICK_DIV - 1);

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  typedef enum logic {
    PH_HIGH = 1'b0,
    PH_LOW = 1'b1
  } icg_phase_t;

  // Bus clock phase at which a pending latch write lands
  typedef enum logic {
    BUS_FALL = 1'b0,
    BUS_RISE = 1'b1
  } icg_bus_edge_t;

endpackage

/* File: src/icg_top.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// (RQ1) Carrier made by counting clocks high then low; period is their sum.
// (RQ2) One count step equals one oscillator clock period.
// (RQ3) Two count-value sets; time mode uses only the primary set.
// (RQ4) FSK mode swaps count sets whenever the modulator requests a switch.
// (RQ5) Baseband select holds the carrier to the modulator continuously high.
// (RQ6) Carrier counts only while enabled and baseband select is clear.
// (RQ7) Six-bit up counter compares after increment, clears and swaps compare.
// (RQ8) High match drives carrier low; low match drives it high; repeats.
// (RQ9) Carrier frequency is clock over high plus low; counts 1 to 63.
// (RQ10) Halve select at control bit 6 halves the carrier frequency.
// (RQ11) Enabled: modulator output drives the pin; else the software latch.
// (RQ12) Output latch read and written through bit 7 of primary registers.
// (RQ13) Latch updates on either bus clock edge, full oscillator resolution.
// (RQ14) Modulator tick: system time baseband_select in time mode, carrier in FSK.
// (RQ15) Modulator time baseband_select ticks once per eight oscillator periods, sixteen with halve select set.
// (RQ16) Software loads nonzero counts before enabling; reset clears counts to zero.
// (RQ17) Reset clears the output latch.
// (RQ18) Negative-edge bit lands on falling bus edge; positive one later.
// (RQ19) On enable the counter starts at zero, high phase, primary set.
// (RQ20) Set switch takes effect at the next carrier period boundary.
module icg_top (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_mod_gate,
  input wire logic i_mod_switch,
  output logic o_carrier,
  output logic o_mod_tick,
  output logic o_infrared_out_pin
);

  typedef struct packed {
    logic enable;
    logic baseband;
    logic fsk;
    logic halve;
    logic [5:0] pri_high;
    logic [5:0] pri_low;
    logic [5:0] sec_high;
    logic [5:0] sec_low;
    logic latch;
    logic pend_valid;
    logic pend_value;
    icg_pkg::icg_bus_edge_t pend_edge;
    logic bus_phase;
    logic prescale;
    logic [5:0] count;
    icg_pkg::icg_phase_t phase;
    logic set_sel;
    logic switch_pend;
    logic carrier;
    logic pin;
    logic tick;
    logic [2:0] tick_count;
    logic a_valid;
    logic a_write;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
  } icg_state_t;

  icg_state_t state_ff;
  icg_state_t nxt_state;

  ////////////////////////////////////////////////////////////////////////////
  // Compare value for a given set and phase
  function automatic logic [5:0] compare_value(
    input icg_state_t s,
    input logic sel,
    input icg_pkg::icg_phase_t ph
  );
    logic [5:0] v;
    if (sel) begin
      v = (ph == icg_pkg::PH_HIGH) ? s.sec_high : s.sec_low;
    end else begin
      v = (ph == icg_pkg::PH_HIGH) ? s.pri_high : s.pri_low;
    end
    return v;
  endfunction

  // Read view of a register; unmapped words read zero
  function automatic logic [31:0] read_word(
    input icg_state_t s,
    input logic [7:0] addr
  );
    logic [31:0] d;
    d = 32'h0000_0000;
    case (addr)
      icg_pkg::OFF_CTRL: begin
        d[icg_pkg::BIT_ENABLE] = s.enable;
        d[icg_pkg::BIT_BASEBAND] = s.baseband;
        d[icg_pkg::BIT_FSK] = s.fsk;
        d[icg_pkg::BIT_HALVE] = s.halve;
      end
      icg_pkg::OFF_PRI_HIGH: begin
        d[icg_pkg::CNT_W-1:0] = s.pri_high;
        d[icg_pkg::BIT_LATCH] = s.latch; // RQ12
      end
      icg_pkg::OFF_PRI_LOW: begin
        d[icg_pkg::CNT_W-1:0] = s.pri_low;
        d[icg_pkg::BIT_LATCH] = s.latch; // RQ12
      end
      icg_pkg::OFF_SEC_HIGH: begin
        d[icg_pkg::CNT_W-1:0] = s.sec_high;
      end
      icg_pkg::OFF_SEC_LOW: begin
        d[icg_pkg::CNT_W-1:0] = s.sec_low;
      end
      icg_pkg::OFF_STATUS: begin
        d[icg_pkg::CNT_W-1:0] = s.count;
        d[icg_pkg::BIT_ST_CARRIER] = s.carrier;
        d[icg_pkg::BIT_ST_PHASE] = s.phase;
        d[icg_pkg::BIT_ST_SET] = s.set_sel;
      end
      default: begin
        d = 32'h0000_0000;
      end
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic gen_run;
  logic step;
  logic [5:0] count_inc;
  logic [5:0] cmp;
  logic at_match;
  logic period_end;
  logic take;
  logic mod_out;

  always_comb begin
    nxt_state = state_ff;

    // Data phase of a previously accepted write
    if (state_ff.a_valid && state_ff.a_write) begin
      case (state_ff.a_addr)
        icg_pkg::OFF_CTRL: begin
          nxt_state.enable = i_hwdata[icg_pkg::BIT_ENABLE];
          nxt_state.baseband = i_hwdata[icg_pkg::BIT_BASEBAND];
          nxt_state.fsk = i_hwdata[icg_pkg::BIT_FSK];
          nxt_state.halve = i_hwdata[icg_pkg::BIT_HALVE]; // RQ10
        end
        icg_pkg::OFF_PRI_HIGH: begin
          nxt_state.pri_high = i_hwdata[icg_pkg::CNT_W-1:0];
          nxt_state.pend_valid = 1'b1; // RQ18
          nxt_state.pend_value = i_hwdata[icg_pkg::BIT_LATCH];
          nxt_state.pend_edge = icg_pkg::BUS_FALL;
        end
        icg_pkg::OFF_PRI_LOW: begin
          nxt_state.pri_low = i_hwdata[icg_pkg::CNT_W-1:0];
          nxt_state.pend_valid = 1'b1; // RQ18
          nxt_state.pend_value = i_hwdata[icg_pkg::BIT_LATCH];
          nxt_state.pend_edge = icg_pkg::BUS_RISE;
        end
        icg_pkg::OFF_SEC_HIGH: begin
          nxt_state.sec_high = i_hwdata[icg_pkg::CNT_W-1:0];
        end
        icg_pkg::OFF_SEC_LOW: begin
          nxt_state.sec_low = i_hwdata[icg_pkg::CNT_W-1:0];
        end
        default: begin
          nxt_state.a_valid = 1'b0;
        end
      endcase
    end

    // Bus clock runs at half the oscillator; latch lands on the chosen edge
    nxt_state.bus_phase = ~state_ff.bus_phase; // RQ13
    if (state_ff.pend_valid && (state_ff.bus_phase == state_ff.pend_edge)) begin
      nxt_state.latch = state_ff.pend_value; // RQ18
      if (!(state_ff.a_valid && state_ff.a_write &&
            (state_ff.a_addr == icg_pkg::OFF_PRI_HIGH ||
             state_ff.a_addr == icg_pkg::OFF_PRI_LOW))) begin
        nxt_state.pend_valid = 1'b0;
      end
    end

    // Address phase capture; zero wait states
    take = i_hsel && i_hready &&
           (i_htrans == icg_pkg::HTRANS_NONSEQ || i_htrans == icg_pkg::HTRANS_SEQ);
    nxt_state.a_valid = take;
    nxt_state.a_write = take && i_hwrite;
    nxt_state.a_addr = {i_haddr[7:2], 2'b00};
    // Read view includes a write landing this cycle
    nxt_state.hrdata = (take && !i_hwrite) ? read_word(nxt_state, {i_haddr[7:2], 2'b00}) :
                       32'h0000_0000;

    // Carrier generator
    gen_run = state_ff.enable && !state_ff.baseband; // RQ6
    step = gen_run && (!state_ff.halve || state_ff.prescale); // RQ10 RQ2
    count_inc = state_ff.count + 6'h01; // RQ7
    cmp = compare_value(state_ff, state_ff.set_sel, state_ff.phase); // RQ3
    at_match = step && (count_inc == cmp); // RQ9
    period_end = at_match && (state_ff.phase == icg_pkg::PH_LOW); // RQ1

    if (i_mod_switch && state_ff.fsk && gen_run) begin
      nxt_state.switch_pend = 1'b1; // RQ4
    end

    if (!gen_run) begin
      nxt_state.prescale = 1'b0;
      nxt_state.count = icg_pkg::RST_COUNT; // RQ19
      nxt_state.phase = icg_pkg::PH_HIGH;
      nxt_state.set_sel = 1'b0;
      nxt_state.switch_pend = 1'b0;
      // Opening the high phase at once keeps the first pulse whole
      nxt_state.carrier = nxt_state.enable; // RQ5 RQ19
    end else begin
      nxt_state.prescale = ~state_ff.prescale;
      nxt_state.carrier = (state_ff.phase == icg_pkg::PH_HIGH);
      if (step) begin
        nxt_state.count = count_inc; // RQ7
      end
      if (at_match) begin
        nxt_state.count = icg_pkg::RST_COUNT; // RQ7
        case (state_ff.phase)
          icg_pkg::PH_HIGH: begin
            nxt_state.phase = icg_pkg::PH_LOW; // RQ8
          end
          icg_pkg::PH_LOW: begin
            nxt_state.phase = icg_pkg::PH_HIGH; // RQ8
          end
          default: begin
            nxt_state.phase = icg_pkg::PH_HIGH;
          end
        endcase
      end
      if (period_end && (state_ff.switch_pend || i_mod_switch) && state_ff.fsk) begin
        nxt_state.set_sel = ~state_ff.set_sel; // RQ20
        nxt_state.switch_pend = 1'b0;
      end
      if (!state_ff.fsk) begin
        nxt_state.set_sel = 1'b0; // RQ3
      end
      nxt_state.carrier = (nxt_state.phase == icg_pkg::PH_HIGH); // RQ8
    end

    // Modulator time baseband_select: carrier periods in FSK, fixed divide otherwise
    nxt_state.tick = 1'b0;
    if (!state_ff.enable) begin
      nxt_state.tick_count = 3'h0;
    end else if (state_ff.fsk && !state_ff.baseband) begin
      nxt_state.tick = period_end; // RQ14
    end else if (!state_ff.halve || state_ff.bus_phase) begin
      if (state_ff.tick_count == icg_pkg::MOD_TICK_LAST) begin
        nxt_state.tick_count = 3'h0;
        nxt_state.tick = 1'b1; // RQ15
      end else begin
        nxt_state.tick_count = state_ff.tick_count + 3'h1;
      end
    end

    // Transmitter output stage
    mod_out = i_mod_gate && state_ff.carrier; // RQ14
    nxt_state.pin = state_ff.enable ? mod_out : state_ff.latch; // RQ11
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset clears the count values to RST_COUNT; software must load them
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      state_ff <= '0;
      state_ff.latch <= icg_pkg::RST_LATCH; // RQ17
      state_ff.pend_valid <= 1'b0; // RQ17
      state_ff.pri_high <= icg_pkg::RST_COUNT;
      state_ff.pri_low <= icg_pkg::RST_COUNT;
      state_ff.sec_high <= icg_pkg::RST_COUNT;
      state_ff.sec_low <= icg_pkg::RST_COUNT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_hrdata = state_ff.hrdata;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_carrier = state_ff.carrier;
  assign o_mod_tick = state_ff.tick;
  assign o_infrared_out_pin = state_ff.pin;

endmodule

/* File: verif/icg_ir_emitter.sv */
`timescale 1ns/1ps
module icg_ir_emitter (
  input wire logic i_clock,
  input wire logic i_led_drive,
  output int o_flashes
);
  logic last_ff = 1'b0;
  int count_ff = 0;
  assign o_flashes = count_ff;
  // Counts light pulses only; cannot tell latch pulses from carrier
  always @(posedge i_clock) begin
    if (i_led_drive === 1'b1 && last_ff !== 1'b1) count_ff <= count_ff + 1;
    last_ff <= i_led_drive;
  end
endmodule

/* File: verif/icg_chk.sv */
`timescale 1ns/1ps
module icg_chk (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic i_mod_gate,
  input wire logic o_carrier,
  input wire logic o_mod_tick,
  input wire logic o_infrared_out_pin
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  logic aw_ff;
  logic en_ff;
  logic baseband_select_ff;
  wire logic take = i_hsel && i_hready && i_htrans[1];
  // Shadow of enable and baseband, rebuilt from bus writes
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      aw_ff <= 1'b0;
      en_ff <= 1'b0;
      baseband_select_ff <= 1'b0;
    end else begin
      aw_ff <= take && i_hwrite && i_haddr[7:0] == icg_pkg::OFF_CTRL;
      if (aw_ff) en_ff <= i_hwdata[icg_pkg::BIT_ENABLE];
      if (aw_ff) baseband_select_ff <= i_hwdata[icg_pkg::BIT_BASEBAND];
    end
  end
  ////////////////////////////////////////
  property p_rst; $rose(i_resetn) |-> !o_carrier && !o_infrared_out_pin; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_bus; o_hreadyout && !o_hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus not ready or not okay");
  property p_rd; !(take && !i_hwrite) |=> o_hrdata == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("read data outside data phase");
  property p_tick; o_mod_tick |=> !o_mod_tick; endproperty
  a_tick: assert property (p_tick) else $error("tick longer than one cycle");
  property p_gate; o_carrier && i_mod_gate && en_ff ##1 en_ff |-> o_infrared_out_pin; endproperty
  a_gate: assert property (p_gate) else $error("carrier not on pin");
  property p_nogate; !i_mod_gate && en_ff ##1 en_ff |-> !o_infrared_out_pin; endproperty
  a_nogate: assert property (p_nogate) else $error("pin high with gate shut");
  property p_baseband_select; en_ff && baseband_select_ff ##1 en_ff && baseband_select_ff |-> o_carrier; endproperty
  a_baseband_select: assert property (p_baseband_select) else $error("baseband carrier not high");
  property p_off; !en_ff ##1 !en_ff |-> !o_carrier; endproperty
  a_off: assert property (p_off) else $error("carrier runs while disabled");
endmodule
bind icg_top icg_chk chk_u (.i_clock(i_clock), .i_resetn(i_resetn), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata),
  .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .i_mod_gate(i_mod_gate), .o_carrier(o_carrier), .o_mod_tick(o_mod_tick),
  .o_infrared_out_pin(o_infrared_out_pin));

/* File: verif/ir_carrier_generator_output_tb.sv */
`timescale 1ns/1ps
module ir_carrier_generator_output_tb;
  typedef struct packed {logic [5:0] h; logic [5:0] l; logic hv;} icg_row_t;
  logic i_clock = 1'b0, i_resetn = 1'b0, i_hsel = 1'b1, i_hwrite = 1'b0, i_hready;
  logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata, q;
  logic [1:0] i_htrans = 2'h0;
  logic [2:0] i_hsize = 3'h2;
  logic i_mod_gate = 1'b0, i_mod_switch = 1'b0;
  logic o_hreadyout, o_hresp, o_carrier, o_mod_tick, o_infrared_out_pin;
  int miscompares = 0, check_count = 0, cycles = 0, flashes, hi, lo, n, t_rise, t_fall;
  icg_row_t rows [4] = '{'{6'h01, 6'h01, 1'b0}, '{6'h03, 6'h02, 1'b0},
    '{6'h3F, 6'h01, 1'b0}, '{6'h05, 6'h04, 1'b1}};
  assign i_hready = o_hreadyout;
  icg_top dut_u (.i_clock(i_clock), .i_resetn(i_resetn), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_mod_gate(i_mod_gate), .i_mod_switch(i_mod_switch), .o_carrier(o_carrier),
    .o_mod_tick(o_mod_tick), .o_infrared_out_pin(o_infrared_out_pin));
  icg_ir_emitter led_u (.i_clock(i_clock), .i_led_drive(o_infrared_out_pin), .o_flashes(flashes));
  initial begin
    forever #2 i_clock = ~i_clock;
  end
  // Longest run is the 63-count row; 20000 cycles leaves ample margin
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_haddr <= {24'h000000, a};
    i_htrans <= icg_pkg::HTRANS_NONSEQ;
    i_hwrite <= w;
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
    q = o_hrdata;
  endtask
  // Skips any partial period so both phases are whole
  task automatic meas();
    hi = 0;
    lo = 0;
    while (o_carrier !== 1'b0) @(posedge i_clock);
    while (o_carrier !== 1'b1) @(posedge i_clock);
    while (o_carrier === 1'b1) begin
      hi++;
      @(posedge i_clock);
    end
    while (o_carrier === 1'b0) begin
      lo++;
      @(posedge i_clock);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge i_clock);
    i_resetn <= 1'b1;
    chk("pin at reset", {31'h0, o_infrared_out_pin}, 32'h0);
    xfer(1'b0, icg_pkg::OFF_PRI_HIGH, 32'h0);
    chk("latch at reset", q, 32'h0);
    xfer(1'b1, 8'h20, 32'hFFFFFFFF);
    xfer(1'b0, 8'h20, 32'h0);
    chk("unmapped read", q, 32'h0);
    $display("done reset");
    i_mod_gate <= 1'b1;
    foreach (rows[i]) begin
      xfer(1'b1, icg_pkg::OFF_PRI_HIGH, {26'h0, rows[i].h});
      xfer(1'b1, icg_pkg::OFF_PRI_LOW, {26'h0, rows[i].l});
      xfer(1'b1, icg_pkg::OFF_CTRL, {25'h0, rows[i].hv, 6'h01});
      meas();
      n = rows[i].hv ? 2 : 1;
      chk("high time", hi, n * rows[i].h);
      chk("low time", lo, n * rows[i].l);
      xfer(1'b1, icg_pkg::OFF_CTRL, 32'h0);
    end
    $display("done table");
    n = flashes;
    xfer(1'b1, icg_pkg::OFF_PRI_HIGH, 32'h83);
    t_rise = cycles;
    repeat (4) begin
      @(posedge i_clock);
      if (o_infrared_out_pin !== 1'b1) t_rise = cycles;
    end
    chk("pin set by latch", {31'h0, o_infrared_out_pin}, 32'h1);
    xfer(1'b0, icg_pkg::OFF_PRI_HIGH, 32'h0);
    chk("latch readback", q, 32'h83);
    xfer(1'b1, icg_pkg::OFF_PRI_LOW, 32'h02);
    t_fall = cycles;
    repeat (4) begin
      @(posedge i_clock);
      if (o_infrared_out_pin !== 1'b0) t_fall = cycles;
    end
    chk("pin cleared", {31'h0, o_infrared_out_pin}, 32'h0);
    // Falling-edge and rising-edge writes land on opposite clock phases
    chk("latch edge parity", (t_fall - t_rise) % 2, 32'h1);
    xfer(1'b0, icg_pkg::OFF_PRI_HIGH, 32'h0);
    chk("shared latch", q, 32'h03);
    chk("flashes", flashes - n, 32'h1);
    xfer(1'b1, icg_pkg::OFF_PRI_HIGH, 32'h83);
    repeat (4) @(posedge i_clock);
    chk("latch set again", {31'h0, o_infrared_out_pin}, 32'h1);
    // Mid-run reset must clear a latch that is set
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_resetn <= 1'b1;
    xfer(1'b0, icg_pkg::OFF_PRI_HIGH, 32'h0);
    chk("latch after reset", q, 32'h0);
    chk("pin after reset", {31'h0, o_infrared_out_pin}, 32'h0);
    $display("done latch");
    xfer(1'b1, icg_pkg::OFF_CTRL, 32'h03);
    repeat (10) @(posedge i_clock);
    chk("baseband carrier", {31'h0, o_carrier}, 32'h1);
    n = 0;
    repeat (80) begin
      @(posedge i_clock);
      if (o_mod_tick === 1'b1) n++;
    end
    chk("ticks in 80", n, 32'hA);
    xfer(1'b1, icg_pkg::OFF_CTRL, 32'h0);
    $display("done baseband");
    xfer(1'b1, icg_pkg::OFF_PRI_HIGH, 32'h02);
    xfer(1'b1, icg_pkg::OFF_PRI_LOW, 32'h02);
    xfer(1'b1, icg_pkg::OFF_SEC_HIGH, 32'h05);
    xfer(1'b1, icg_pkg::OFF_SEC_LOW, 32'h03);
    xfer(1'b1, icg_pkg::OFF_CTRL, 32'h05);
    meas();
    chk("fsk first high", hi, 32'h2);
    i_mod_switch <= 1'b1;
    @(posedge i_clock);
    i_mod_switch <= 1'b0;
    meas();
    chk("switched high", hi, 32'h5);
    chk("switched low", lo, 32'h3);
    n = 0;
    repeat (24) begin
      @(posedge i_clock);
      if (o_mod_tick === 1'b1) n++;
    end
    chk("fsk ticks in 24", n, 32'h3);
    xfer(1'b0, icg_pkg::OFF_STATUS, 32'h0);
    chk("active set", {31'h0, q[icg_pkg::BIT_ST_SET]}, 32'h1);
    i_mod_gate <= 1'b0;
    xfer(1'b1, icg_pkg::OFF_CTRL, 32'h0);
    xfer(1'b1, icg_pkg::OFF_CTRL, 32'h05);
    hi = 0;
    @(posedge i_clock);
    while (o_carrier === 1'b1) begin
      hi++;
      @(posedge i_clock);
    end
    chk("first pulse", hi, 32'h2);
    meas();
    chk("restart high", hi, 32'h2);
    chk("restart low", lo, 32'h2);
    i_mod_switch <= 1'b1;
    @(posedge i_clock);
    i_mod_switch <= 1'b0;
    meas();
    chk("second switch", hi, 32'h5);
    // Leaving FSK mid-period may wrap the counter once; meas skips that period
    xfer(1'b1, icg_pkg::OFF_CTRL, 32'h01);
    meas();
    chk("time mode high", hi, 32'h2);
    chk("time mode low", lo, 32'h2);
    $display("done fsk");
    give_verdict();
  end
endmodule
